/* rtl/ior_regs.svh */
// offsets, field positions and reset values of the relocation/snapshot block
// assumes 32-bit storage words with bit 0 as the most significant bit
`ifndef IOR_REGS_SVH
`define IOR_REGS_SVH

// relocation register table in low storage, one word per key
`define IOR_RELOC_BASE    24'h000040
`define IOR_RELOC_STRIDE  24'h000004
// descriptors are a doubleword apart
`define IOR_DESC_STEP     24'h000008
// start descriptor: key bits 0-3, zero-key bit 4, address bits 8-31
`define IOR_SD_KEY_HI     31
`define IOR_SD_KEY_LO     28
`define IOR_SD_ZERO       27
// command descriptor: command code bits 0-7, address bits 8-31
`define IOR_CD_CMD_HI     31
`define IOR_CD_CMD_LO     24
`define IOR_ADDR_HI       23
// command code: key-restore flag at code bit 3, jump code in bits 4-7
`define IOR_CMD_KRESTORE  4
`define IOR_JUMP_CODE     4'h8
// record: check bit at record bit 13
`define IOR_REC_CHECK     18
`define IOR_STACK_REC_IDX 6'h3E
`define IOR_RESET_MODE    3'h7
`define IOR_ZERO24        24'h000000
`define IOR_ZERO32        32'h00000000

`endif

/* rtl/ior_pkg.sv */
// types shared by the relocation/snapshot block
// assumes ior_regs.svh carries the numeric constants
package ior_pkg;

  // 31 interface lines; tags[12] is address out, tags[0] is request in
  typedef struct packed {
    logic [12:0] tags;
    logic        bus_out_par;
    logic        bus_in_par;
    logic [7:0]  bus_in;
    logic [7:0]  bus_out;
  } ior_lines_t;

  typedef struct packed {
    logic        zero_key;
    logic        check;
    logic [2:0]  reset_mode;
    logic [7:0]  cmd;
    logic [23:0] data_addr;
  } ior_held_t;

  typedef enum logic [1:0] {PH_START, PH_DATA, PH_JUMP} ior_phase_t;

endpackage

/* rtl/ior_reloc_sel.sv */
// chooses where a relocation value comes from for each fetch kind
// assumes the caller holds the start key and the held zero-key flag
`timescale 1ns/1ps
`include "ior_regs.svh"

module ior_reloc_sel (
  // what is being relocated
  input  wire ior_pkg::ior_phase_t phase,
  input  wire logic                is_mux,
  input  wire logic                zero_key,
  input  wire logic                k_flag,
  input  wire logic [3:0]          start_key,
  // decision
  output logic                     need_read,
  output logic [3:0]               rd_key,
  output logic                     clear_zero,
  output logic                     save_internal
);

  logic restore;

  always_comb begin
    restore       = (phase == ior_pkg::PH_JUMP) && zero_key && k_flag;
    need_read     = 1'b1;
    rd_key        = zero_key ? 4'h0 : start_key;
    clear_zero    = restore;
    save_internal = 1'b0;
    case (phase)
      ior_pkg::PH_START: begin
        save_internal = !is_mux;
      end
      ior_pkg::PH_DATA: begin
        need_read = is_mux;
      end
      ior_pkg::PH_JUMP: begin
        // restore forces the original key; otherwise the k flag is ignored
        need_read     = is_mux || restore;
        rd_key        = restore ? start_key : (zero_key ? 4'h0 : start_key);
        save_internal = restore && !is_mux;
      end
      default: begin
        need_read = 1'b0;
      end
    endcase
  end

endmodule

/* rtl/ior_snapshot.sv */
// interface-error snapshot capture and the stack record register
// assumes err_detect is a one-cycle pulse aligned with the faulty lines
`timescale 1ns/1ps
`include "ior_regs.svh"

module ior_snapshot (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // detection
  input  wire logic                err_detect,
  input  wire ior_pkg::ior_lines_t lines,
  input  wire logic                is_mux,
  // stack register access by software
  input  wire logic                load_stack,
  input  wire logic [31:0]         load_data,
  output logic [31:0]              interface_error_record,
  // selector record
  output logic [31:0]              sel_record
);

  logic [31:0] fmt;

  // same layout serves the stack word and the second status word
  assign fmt = {lines.tags, 1'b1, lines.bus_out_par, lines.bus_in_par,
                lines.bus_in, lines.bus_out};

  // a pending unread record blocks the capture; a capture beats a clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      interface_error_record <= `IOR_ZERO32;
    end else if (is_mux && err_detect && !interface_error_record[`IOR_REC_CHECK]) begin
      interface_error_record <= fmt;
    end else if (load_stack) begin
      interface_error_record <= load_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sel_record <= `IOR_ZERO32;
    end else if (!is_mux && err_detect) begin
      sel_record <= fmt;
    end
  end

  property p_snap_take;
    @(posedge ref_clk) disable iff (!rst_n)
    (is_mux && err_detect && !interface_error_record[`IOR_REC_CHECK])
      |=> interface_error_record == $past(fmt);
  endproperty
  a_snap_take: assert property (p_snap_take) else $error("record not captured");

  property p_snap_keep;
    @(posedge ref_clk) disable iff (!rst_n)
    (err_detect && interface_error_record[`IOR_REC_CHECK] && !load_stack)
      |=> $stable(interface_error_record);
  endproperty
  a_snap_keep: assert property (p_snap_keep) else $error("unread record overwritten");

  property p_check_bit;
    @(posedge ref_clk) disable iff (!rst_n)
    (!is_mux && err_detect) |=> sel_record[`IOR_REC_CHECK] &&
      sel_record[7:0] == $past(lines.bus_out);
  endproperty
  a_check_bit: assert property (p_check_bit) else $error("selector record wrong");

endmodule

/* rtl/ior_channel.sv */
// channel descriptor fetch with relocation, plus interface-error reporting
// assumes a single-word storage read port answered by a one-cycle ack
`timescale 1ns/1ps
`include "ior_regs.svh"

module ior_channel #(
  parameter bit IS_MUX = 1'b0
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // operation requests
  input  wire logic                op_start,
  input  wire logic [31:0]         start_descriptor,
  input  wire logic                op_chain,
  output logic                     busy,
  output logic                     fetch_done,
  output ior_pkg::ior_held_t       held_descriptor,
  output logic [23:0]              held_next_pointer,
  output logic [23:0]              reloc_internal,
  // main storage read port
  output logic                     mem_req,
  output logic [23:0]              mem_addr,
  input  wire logic [31:0]         mem_rdata,
  input  wire logic                mem_ack,
  // interface error
  input  wire logic                err_detect,
  input  wire ior_pkg::ior_lines_t lines,
  // selector status store
  output logic                     irq_req,
  input  wire logic                prio_grant,
  input  wire logic [31:0]         status_word1,
  output logic                     status_valid,
  output logic [63:0]              selector_status_word,
  // stack register 62 access
  input  wire logic                load_stack,
  input  wire logic [31:0]         load_data,
  output logic [31:0]              interface_error_record
);

  // ==========================================================
  // state
  typedef enum logic [2:0] {S_IDLE, S_RELOC, S_FETCH, S_DECODE} ior_state_t;

  ior_state_t          state;
  ior_pkg::ior_phase_t phase;
  logic [3:0]          start_key;
  logic [23:0]         base_addr;
  logic [23:0]         reloc_cur;
  logic [31:0]         desc;
  logic                need_read;
  logic [3:0]          rd_key;
  logic                clear_zero;
  logic                save_internal;
  logic                is_jump;
  logic [31:0]         sel_record;
  ior_pkg::ior_phase_t dec_phase;
  logic [23:0]         jump_target;
  logic                save_q;

  function automatic logic [23:0] reloc_addr(input logic [3:0] key);
    reloc_addr = `IOR_RELOC_BASE + (`IOR_RELOC_STRIDE * {20'h00000, key});
  endfunction

  function automatic logic [23:0] add24(input logic [23:0] a, input logic [23:0] b);
    add24 = a + b;
  endfunction

  assign is_jump   = desc[`IOR_CD_CMD_LO+3:`IOR_CD_CMD_LO] == `IOR_JUMP_CODE;
  // a descriptor reached by chaining or by a jump is relocated as a chained one
  assign dec_phase = (state != S_DECODE) ? phase :
                     is_jump ? ior_pkg::PH_JUMP :
                     (phase == ior_pkg::PH_START) ? ior_pkg::PH_START : ior_pkg::PH_DATA;

  ior_reloc_sel u_sel (
    .phase         (dec_phase),
    .is_mux        (IS_MUX),
    .zero_key      (held_descriptor.zero_key),
    .k_flag        (desc[`IOR_CD_CMD_LO+`IOR_CMD_KRESTORE]),
    .start_key     (start_key),
    .need_read     (need_read),
    .rd_key        (rd_key),
    .clear_zero    (clear_zero),
    .save_internal (save_internal)
  );

  ior_snapshot u_snap (
    .ref_clk                (ref_clk),
    .rst_n                  (rst_n),
    .err_detect             (err_detect),
    .lines                  (lines),
    .is_mux                 (IS_MUX),
    .load_stack             (load_stack),
    .load_data              (load_data),
    .interface_error_record (interface_error_record),
    .sel_record             (sel_record)
  );

  // ==========================================================
  // storage port
  logic [3:0] key_q;

  assign busy    = state != S_IDLE;
  assign mem_req = (state == S_RELOC) || (state == S_FETCH);
  assign mem_addr = (state == S_RELOC) ? reloc_addr(key_q) : held_next_pointer;

  // ==========================================================
  // fetch sequencer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state      <= S_IDLE;
      phase      <= ior_pkg::PH_START;
      fetch_done <= 1'b0;
      key_q      <= 4'h0;
      start_key  <= 4'h0;
      base_addr  <= `IOR_ZERO24;
      reloc_cur  <= `IOR_ZERO24;
      desc       <= `IOR_ZERO32;
    end else begin
      fetch_done <= 1'b0;
      case (state)
        S_IDLE: begin
          if (op_start) begin
            start_key <= start_descriptor[`IOR_SD_KEY_HI:`IOR_SD_KEY_LO];
            key_q     <= start_descriptor[`IOR_SD_ZERO] ? 4'h0 :
                         start_descriptor[`IOR_SD_KEY_HI:`IOR_SD_KEY_LO];
            base_addr <= start_descriptor[`IOR_ADDR_HI:0];
            phase     <= ior_pkg::PH_START;
            state     <= S_RELOC;
          end else if (op_chain) begin
            phase <= ior_pkg::PH_DATA;
            state <= S_FETCH;
          end
        end
        S_RELOC: begin
          if (mem_ack) begin
            reloc_cur <= mem_rdata[`IOR_ADDR_HI:0];
            if (phase == ior_pkg::PH_DATA) begin
              fetch_done <= 1'b1;
              state      <= S_IDLE;
            end else begin
              state <= S_FETCH;
            end
          end
        end
        S_FETCH: begin
          if (mem_ack) begin
            desc  <= mem_rdata;
            state <= S_DECODE;
          end
        end
        S_DECODE: begin
          key_q <= rd_key;
          if (is_jump) begin
            phase <= ior_pkg::PH_JUMP;
            state <= need_read ? S_RELOC : S_FETCH;
          end else if (phase == ior_pkg::PH_START) begin
            fetch_done <= 1'b1;
            state      <= S_IDLE;
          end else begin
            phase <= ior_pkg::PH_DATA;
            if (need_read) begin
              state <= S_RELOC;
            end else begin
              fetch_done <= 1'b1;
              state      <= S_IDLE;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // absolute next-descriptor pointer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      held_next_pointer <= `IOR_ZERO24;
    end else if (state == S_RELOC && mem_ack && phase != ior_pkg::PH_DATA) begin
      // a jump relocates its own target, not the start address
      held_next_pointer <= add24((phase == ior_pkg::PH_JUMP) ? jump_target : base_addr,
                                 mem_rdata[`IOR_ADDR_HI:0]);
    end else if (state == S_DECODE && is_jump && !need_read) begin
      held_next_pointer <= add24(desc[`IOR_ADDR_HI:0], reloc_internal);
    end else if (state == S_FETCH && mem_ack) begin
      held_next_pointer <= held_next_pointer + `IOR_DESC_STEP;
    end
  end

  // jump target comes from the descriptor just decoded
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      jump_target <= `IOR_ZERO24;
    end else if (state == S_DECODE) begin
      jump_target <= desc[`IOR_ADDR_HI:0];
    end
  end

  // selector internal relocation register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reloc_internal <= `IOR_ZERO24;
    end else if (state == S_RELOC && mem_ack && save_q) begin
      reloc_internal <= mem_rdata[`IOR_ADDR_HI:0];
    end
  end

  // zero-key is already cleared when a restoring jump reads, so the save is latched at decode
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      save_q <= 1'b0;
    end else if (state == S_IDLE && op_start) begin
      save_q <= !IS_MUX;
    end else if (state == S_DECODE) begin
      save_q <= save_internal;
    end
  end

  // ==========================================================
  // held descriptor
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      held_descriptor <= '0;
    end else begin
      if (state == S_IDLE && op_start) begin
        held_descriptor.zero_key <= start_descriptor[`IOR_SD_ZERO];
        held_descriptor.check    <= 1'b0;
      end else if (state == S_DECODE && is_jump && clear_zero) begin
        held_descriptor.zero_key <= 1'b0;
      end
      if (state == S_DECODE && !is_jump) begin
        held_descriptor.cmd <= desc[`IOR_CD_CMD_HI:`IOR_CD_CMD_LO];
        if (phase == ior_pkg::PH_START) begin
          held_descriptor.data_addr <= add24(desc[`IOR_ADDR_HI:0], reloc_cur);
        end else if (!need_read) begin
          held_descriptor.data_addr <= add24(desc[`IOR_ADDR_HI:0], reloc_internal);
        end
      end else if (state == S_RELOC && mem_ack && phase == ior_pkg::PH_DATA) begin
        held_descriptor.data_addr <= add24(desc[`IOR_ADDR_HI:0], mem_rdata[`IOR_ADDR_HI:0]);
      end
      // capture does not hold off the rest of the error handling
      if (IS_MUX && err_detect) begin
        held_descriptor.check      <= 1'b1;
        held_descriptor.reset_mode <= `IOR_RESET_MODE;
      end
    end
  end

  // ==========================================================
  // selector interrupt and status store
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_req              <= 1'b0;
      status_valid         <= 1'b0;
      selector_status_word <= 64'h0000000000000000;
    end else begin
      status_valid <= 1'b0;
      if (!IS_MUX && err_detect) begin
        irq_req <= 1'b1;
      end else if (irq_req && prio_grant) begin
        irq_req              <= 1'b0;
        status_valid         <= 1'b1;
        selector_status_word <= {status_word1, sel_record};
      end
    end
  end

  // ==========================================================
  // checks
  sequence s_start_reloc;
    state == S_RELOC && phase == ior_pkg::PH_START && mem_ack;
  endsequence

  property p_first_fetch;
    @(posedge ref_clk) disable iff (!rst_n)
    s_start_reloc |=> state == S_FETCH &&
      mem_addr == $past(add24(base_addr, mem_rdata[`IOR_ADDR_HI:0]));
  endproperty
  a_first_fetch: assert property (p_first_fetch) else $error("first fetch address wrong");

  property p_start_key;
    @(posedge ref_clk) disable iff (!rst_n)
    (state == S_IDLE && op_start) |=> mem_addr == reloc_addr(
      $past(start_descriptor[`IOR_SD_ZERO]) ? 4'h0 : start_key);
  endproperty
  a_start_key: assert property (p_start_key) else $error("start key selection wrong");

  property p_sel_no_read;
    @(posedge ref_clk) disable iff (!rst_n)
    (!IS_MUX && state == S_DECODE && !is_jump && phase != ior_pkg::PH_START)
      |=> state == S_IDLE && fetch_done;
  endproperty
  a_sel_no_read: assert property (p_sel_no_read) else $error("selector read on chain");

  property p_restore;
    @(posedge ref_clk) disable iff (!rst_n)
    (state == S_DECODE && is_jump && held_descriptor.zero_key &&
     desc[`IOR_CD_CMD_LO+`IOR_CMD_KRESTORE])
      |=> !held_descriptor.zero_key && key_q == start_key && state == S_RELOC;
  endproperty
  a_restore: assert property (p_restore) else $error("key restore not applied");

  property p_irq_store;
    @(posedge ref_clk) disable iff (!rst_n)
    (irq_req && prio_grant && !err_detect)
      |=> status_valid && selector_status_word[31:0] == sel_record;
  endproperty
  a_irq_store: assert property (p_irq_store) else $error("status store wrong");

  property p_mux_check;
    @(posedge ref_clk) disable iff (!rst_n)
    (IS_MUX && err_detect) |=> held_descriptor.check &&
      held_descriptor.reset_mode == `IOR_RESET_MODE;
  endproperty
  a_mux_check: assert property (p_mux_check) else $error("held check not set");

endmodule

/* test/ior_store_model.sv */
// storage model answering single-word reads from a sparse word map
// assumes the bench fills the map before each operation starts
`timescale 1ns/1ps

module ior_store_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // read port
  input  wire logic        mem_req,
  input  wire logic [23:0] mem_addr,
  output logic      [31:0] mem_rdata,
  output logic             mem_ack,
  // pacing
  input  wire logic        slow
);
  logic [31:0] mem [logic [23:0]];
  logic [1:0]  wait_cnt;

  // idle data lines alternate between the inverse of the last word and the word itself
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h00000000;
      wait_cnt  <= 2'h0;
    end else if (mem_req && !mem_ack && (!slow || wait_cnt == 2'h3)) begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'hFFFFFFFF;
      wait_cnt  <= 2'h0;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_cnt  <= (mem_req && !mem_ack) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule

/* test/io_channel_relocation_snapshot_test.sv */
// bench for relocated descriptor fetches and interface error snapshots
// assumes a selector copy and a multiplexer copy on shared stimulus
`timescale 1ns/1ps
`include "ior_regs.svh"

module io_channel_relocation_snapshot_test;
  logic                ref_clk = 1'b0;
  logic                rst_n, op_start, op_chain, err_detect, prio_grant, load_stack, slow;
  logic [31:0]         start_descriptor, status_word1, load_data, seed, d, rec;
  ior_pkg::ior_lines_t lines;
  logic [31:0]         rd_s, rd_m;
  logic                req_s, req_m, ack_s, ack_m, z, kf;
  logic [23:0]         ad_s, ad_m, rel, r, a;
  logic [3:0]          key;
  logic [23:0]         rtab [16];
  logic [48:0]         qf_s[$], qf_m[$];
  logic [63:0]         q_stat[$];
  logic [31:0]         q_rec[$];
  logic [31:0]         last_rec = 32'h00000000;
  int                  n_fail = 0, n_checks = 0;

  always #20 ref_clk = ~ref_clk;

  ior_channel #(.IS_MUX(1'b0)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .op_start(op_start),
    .start_descriptor(start_descriptor), .op_chain(op_chain), .busy(), .fetch_done(),
    .held_descriptor(), .held_next_pointer(), .reloc_internal(), .mem_req(req_s),
    .mem_addr(ad_s), .mem_rdata(rd_s), .mem_ack(ack_s), .err_detect(err_detect),
    .lines(lines), .irq_req(), .prio_grant(prio_grant), .status_word1(status_word1),
    .status_valid(), .selector_status_word(), .load_stack(load_stack),
    .load_data(load_data), .interface_error_record());
  ior_channel #(.IS_MUX(1'b1)) uut_mux (
    .ref_clk(ref_clk), .rst_n(rst_n), .op_start(op_start),
    .start_descriptor(start_descriptor), .op_chain(op_chain), .busy(), .fetch_done(),
    .held_descriptor(), .held_next_pointer(), .reloc_internal(), .mem_req(req_m),
    .mem_addr(ad_m), .mem_rdata(rd_m), .mem_ack(ack_m), .err_detect(err_detect),
    .lines(lines), .irq_req(), .prio_grant(prio_grant), .status_word1(status_word1),
    .status_valid(), .selector_status_word(), .load_stack(load_stack),
    .load_data(load_data), .interface_error_record());
  ior_store_model m_s (.ref_clk(ref_clk), .rst_n(rst_n), .mem_req(req_s), .mem_addr(ad_s),
    .mem_rdata(rd_s), .mem_ack(ack_s), .slow(slow));
  ior_store_model m_m (.ref_clk(ref_clk), .rst_n(rst_n), .mem_req(req_m), .mem_addr(ad_m),
    .mem_rdata(rd_m), .mem_ack(ack_m), .slow(slow));

  wire [48:0] got_s = {uut.held_descriptor.zero_key, uut.held_descriptor.data_addr,
                       uut.held_next_pointer};
  wire [48:0] got_m = {uut_mux.held_descriptor.zero_key, uut_mux.held_descriptor.data_addr,
                       uut_mux.held_next_pointer};

  // ==========================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cmp_f(input string what, input logic [48:0] exp, input logic [48:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_w(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic poke(input logic [23:0] adr, input logic [31:0] w);
    m_s.mem[adr] = w;
    m_m.mem[adr] = w;
  endtask

  // both copies see the same storage, so their notes are identical
  task automatic run_op(input logic chain, input logic [48:0] e);
    int n;
    qf_s.push_back(e);
    qf_m.push_back(e);
    op_chain = chain;
    op_start = !chain;
    @(negedge ref_clk);
    op_start = 1'b0;
    op_chain = 1'b0;
    n = 0;
    while ((uut.busy !== 1'b0 || uut_mux.busy !== 1'b0) && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 300) cmp_w("busy", 64'h0, 64'h1);
    repeat (2) @(negedge ref_clk);
  endtask

  // ==========================================
  // result watcher
  always @(posedge ref_clk) begin
    #1;
    if (uut.fetch_done === 1'b1) begin
      cmp_f("sel fetch", qf_s.size() ? qf_s.pop_front() : 'x, got_s);
    end
    if (uut_mux.fetch_done === 1'b1) begin
      cmp_f("mux fetch", qf_m.size() ? qf_m.pop_front() : 'x, got_m);
    end
    if (uut.status_valid === 1'b1) begin
      cmp_w("status word", q_stat.size() ? q_stat.pop_front() : 'x, uut.selector_status_word);
    end
    if (uut_mux.interface_error_record !== last_rec) begin
      cmp_w("stack record", q_rec.size() ? {32'h0, q_rec.pop_front()} : 'x, {32'h0, uut_mux.interface_error_record});
      last_rec = uut_mux.interface_error_record;
    end
  end

  initial begin
    #(40 * 4000);
    n_fail++;
    give_verdict();
  end

  // ==========================================
  // stimulus
  initial begin
    {rst_n, op_start, op_chain, err_detect, prio_grant, load_stack, slow} = 7'h00;
    {start_descriptor, status_word1, load_data} = 96'h0;
    lines = '0;
    seed = 32'h0fe0;
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    // distinct per key so a wrong table index always shows
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      rtab[k] = {1'b1, seed[2:0], 4'(k), 16'h0000};
      poke(`IOR_RELOC_BASE + 24'(k) * `IOR_RELOC_STRIDE, {8'h00, rtab[k]});
    end
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      key = (i == 3) ? 4'hF : seed[3:0];
      {kf, z} = 2'(i);
      slow = seed[31];
      rel = {12'h001, seed[16:8], 3'b000};
      r = rtab[z ? 4'h0 : key];
      a = rel + r;
      start_descriptor = {key, z, 3'b000, rel};
      if (i >= 4) begin
        poke(a, {3'b000, kf, `IOR_JUMP_CODE, 12'h003, seed[24:16], 3'b000});
        r = (z && !kf) ? rtab[0] : rtab[key];
        a = {12'h003, seed[24:16], 3'b000} + r;
        z = z & !kf;
      end
      d = {8'h01, seed[27:4]};
      poke(a, d);
      run_op(1'b0, {z, d[23:0] + r, a + `IOR_DESC_STEP});
      cmp_w("internal reloc", {40'h0, r}, {40'h0, uut.reloc_internal});
      cmp_w("held cmd", {48'h0, d[31:24], d[31:24]},
            {48'h0, uut.held_descriptor.cmd, uut_mux.held_descriptor.cmd});
      seed = lfsr(seed);
      a = a + `IOR_DESC_STEP;
      d = {8'h02, seed[23:0]};
      poke(a, d);
      r = z ? rtab[0] : rtab[key];
      run_op(1'b1, {z, d[23:0] + r, a + `IOR_DESC_STEP});
    end
    for (int e = 0; e < 3; e++) begin
      seed = lfsr(seed);
      rec = {seed[30:18], 1'b1, seed[17:0]};
      if (e != 1) q_rec.push_back(rec);
      status_word1 = ~seed;
      q_stat.push_back({~seed, rec});
      lines = seed[30:0];
      err_detect = 1'b1;
      @(negedge ref_clk);
      err_detect = 1'b0;
      lines = ~lines;
      cmp_w("irq request", 64'h1, {63'h0, uut.irq_req});
      if (e == 0) cmp_w("held check", 64'({1'b1, `IOR_RESET_MODE}), {60'h0, uut_mux.held_descriptor.check, uut_mux.held_descriptor.reset_mode});
      prio_grant = 1'b1;
      @(negedge ref_clk);
      prio_grant = 1'b0;
      @(negedge ref_clk);
      cmp_w("irq request", 64'h0, {63'h0, uut.irq_req});
      if (e == 1) begin
        // software clears the record after reading it
        q_rec.push_back(32'h00000000);
        load_data = 32'h00000000;
        load_stack = 1'b1;
        @(negedge ref_clk);
        load_stack = 1'b0;
      end
    end
    repeat (4) @(negedge ref_clk);
    cmp_w("pending notes", 64'h0, 64'(qf_s.size() + qf_m.size() + q_stat.size() + q_rec.size()));
    give_verdict();
  end
endmodule
